/* File: common/eeelpi_map.vh */
// Register map, reset values and timing constants of the EEE low-power-idle control block.
// Assumes a 40 MHz core clock and a 16-bit register port addressed by byte.
//
// Notes on behaviour
// - Status bit 2 is read-only and always reads one: local next-page able.
// - Status bit 1 latches high on a new partner page until cleared.
// - Status bit 0 reads one when the partner can auto-negotiate.
// - After LPI recovery port 2 waits count times 640 ns; count resets to 0x27.
// - Port 2 next-page enable (reset one) turns next-page exchange for EEE on or off.
// - Port 1 next-page enable (reset zero) does the same for port 1.
// - LPI is requested after a queue stays empty for the 16-bit time, 1.3 ms units.
// - The empty-queue LPI request exists only while 100BASE-TX EEE is enabled.
// - One empty-queue wait setting times all three ports.
// - Each port's buffer usage is compared with an 8-bit threshold in 128-byte units.
// - Any one port above the threshold ends LPI on every port.
// - Status bit 14 shows that 100BASE-TX EEE was enabled by next-page exchange.
`ifndef EEELPI_MAP_VH
`define EEELPI_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define EEELPI_OFF_P2_STATUS  8'hF0
`define EEELPI_OFF_RECOVERY   8'hF2
`define EEELPI_OFF_NP_CTRL    8'hF3
`define EEELPI_OFF_EQ_WAIT    8'hF4
`define EEELPI_OFF_BUF_THR    8'hF6

// ****************************************
// Field positions
// ****************************************
`define EEELPI_BIT_RES15      15
`define EEELPI_BIT_HW_EEE     14
`define EEELPI_BIT_TX_LPI_RCV 13
`define EEELPI_BIT_TX_LPI_IND 12
`define EEELPI_BIT_RX_LPI_RCV 11
`define EEELPI_BIT_RX_LPI_IND 10
`define EEELPI_BIT_NP_LOC_AB  6
`define EEELPI_BIT_NP_LOC     5
`define EEELPI_BIT_PD_FAULT   4
`define EEELPI_BIT_LP_NP_AB   3
`define EEELPI_BIT_NP_ABLE    2
`define EEELPI_BIT_PAGE_RCV   1
`define EEELPI_BIT_LP_AN_AB   0
`define EEELPI_BIT_P2_NP_EN   1
`define EEELPI_BIT_P1_NP_EN   0

// ****************************************
// Reset values
// ****************************************
`define EEELPI_RST_RES15      1'h1
`define EEELPI_RST_RECOVERY   8'h27
`define EEELPI_RST_P2_NP_EN   1'h1
`define EEELPI_RST_P1_NP_EN   1'h0
`define EEELPI_RST_EQ_WAIT    16'h03E8
`define EEELPI_RST_BUF_THR    8'h04

// ****************************************
// Timing
// ****************************************
`define EEELPI_CLK_PERIOD_NS  25
`define EEELPI_REC_UNIT_NS    640
`define EEELPI_EQ_UNIT_NS     1300000
`define EEELPI_REC_UNIT_CYC   ((`EEELPI_REC_UNIT_NS + `EEELPI_CLK_PERIOD_NS - 1) / `EEELPI_CLK_PERIOD_NS)
`define EEELPI_EQ_UNIT_CYC    (`EEELPI_EQ_UNIT_NS / `EEELPI_CLK_PERIOD_NS)

`endif

/* File: hw/eeelpi_timer.v */
// Unit timer: a prescaler makes a fixed tick, a saturating counter counts ticks.
// Assumes run and restart come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module eeelpi_timer #(
  parameter PRE_CYC = 26,
  parameter PRE_W   = 16,
  parameter CNT_W   = 16
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Control
  input  wire             run,
  input  wire             restart,
  input  wire [CNT_W-1:0] limit,
  // Result
  output wire             done
);

  reg  [PRE_W-1:0] pre_q;
  reg  [CNT_W-1:0] cnt_q;
  wire             tick;
  wire             clr;

  assign clr  = ~run | restart;
  assign tick = (pre_q == PRE_CYC[PRE_W-1:0] - {{(PRE_W-1){1'b0}}, 1'b1});

  // ****************************************
  // Tick and unit count
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= {PRE_W{1'b0}};
      cnt_q <= {CNT_W{1'b0}};
    end else if (clr) begin
      pre_q <= {PRE_W{1'b0}};
      cnt_q <= {CNT_W{1'b0}};
    end else if (tick) begin
      pre_q <= {PRE_W{1'b0}};
      if (cnt_q != {CNT_W{1'b1}}) begin
        cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end else begin
      pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // Saturation keeps a long-running condition from wrapping back to "not done"
  assign done = run & ~restart & (cnt_q >= limit);

endmodule
`default_nettype wire

/* File: hw/eeelpi_top.v */
// EEE low-power-idle control: port 2 status, next-page enables, LPI request and wake timing.
// Assumes all status inputs come from PHY/MAC logic on core_clk; the register port is synchronous.
`timescale 1ns/1ps
`include "eeelpi_map.vh"
`default_nettype none

module eeelpi_top #(
  parameter NPORT       = 3,
  parameter EQ_UNIT_CYC = `EEELPI_EQ_UNIT_CYC
) (
  // Clock and reset
  input  wire                 core_clk,
  input  wire                 rst_b,
  // Register port
  input  wire [7:0]           reg_addr,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  input  wire [1:0]           reg_be,
  input  wire [15:0]          reg_wdata,
  output reg  [15:0]          reg_rdata,
  output reg                  reg_rvalid,
  // Port 2 auto-negotiation and PCS status
  input  wire                 p2_page_rcv,
  input  wire                 p2_lp_an_able,
  input  wire                 p2_lp_np_able,
  input  wire                 p2_pd_fault,
  input  wire                 p2_tx_lpi_ind,
  input  wire                 p2_rx_lpi_ind,
  // Per-port EEE state and queues
  input  wire [NPORT-1:0]     eee_100bt_en,
  input  wire [NPORT-1:0]     transmit_queue_empty,
  input  wire [NPORT*8-1:0]   buf_usage,
  // Port 2 LPI recovery
  input  wire                 p2_lpi_exit,
  output reg                  p2_tx_hold,
  // Outputs to PHY and MAC
  output wire                 p1_np_en,
  output wire                 p2_np_en,
  output reg  [NPORT-1:0]     lpi_req,
  output reg                  lpi_wake_all
);

  // ****************************************
  // Reset release
  // ****************************************
  reg rst_s1_q;
  reg rst_n_q;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  wire hit_sts;
  wire hit_rec;
  wire hit_eqw;
  wire hit_thr;

  // Word decode: byte address bit 0 only picks the lane, so compare bits 7:1
  localparam [7:0] OFF_STS = `EEELPI_OFF_P2_STATUS;
  localparam [7:0] OFF_REC = `EEELPI_OFF_RECOVERY;
  localparam [7:0] OFF_EQW = `EEELPI_OFF_EQ_WAIT;
  localparam [7:0] OFF_THR = `EEELPI_OFF_BUF_THR;

  assign hit_sts = (reg_addr[7:1] == OFF_STS[7:1]);
  assign hit_rec = (reg_addr[7:1] == OFF_REC[7:1]);
  assign hit_eqw = (reg_addr[7:1] == OFF_EQW[7:1]);
  assign hit_thr = (reg_addr[7:1] == OFF_THR[7:1]);

  // ****************************************
  // Registers
  // ****************************************
  reg        res15_q;
  reg [1:0]  res98_q;
  reg        tx_lpi_rcv_q;
  reg        rx_lpi_rcv_q;
  reg        pd_fault_q;
  reg        page_rcv_q;
  reg [7:0]  rec_time_q;
  reg [1:0]  np_res_q;
  reg        p2_np_en_q;
  reg        p1_np_en_q;
  reg [15:0] eq_wait_q;
  reg [7:0]  buf_thr_q;

  wire sts_wr_hi;
  wire sts_rd_lo;

  assign sts_wr_hi = reg_wr & hit_sts & reg_be[1];
  assign sts_rd_lo = reg_rd & hit_sts;

  always @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      res15_q      <= `EEELPI_RST_RES15;
      res98_q      <= 2'h0;
      tx_lpi_rcv_q <= 1'b0;
      rx_lpi_rcv_q <= 1'b0;
      pd_fault_q   <= 1'b0;
      page_rcv_q   <= 1'b0;
      rec_time_q   <= `EEELPI_RST_RECOVERY;
      np_res_q     <= 2'h0;
      p2_np_en_q   <= `EEELPI_RST_P2_NP_EN;
      p1_np_en_q   <= `EEELPI_RST_P1_NP_EN;
      eq_wait_q    <= `EEELPI_RST_EQ_WAIT;
      buf_thr_q    <= `EEELPI_RST_BUF_THR;
    end else begin
      if (sts_wr_hi) begin
        res15_q <= reg_wdata[`EEELPI_BIT_RES15];
      end
      if (reg_wr & hit_sts & reg_be[1]) begin
        res98_q <= reg_wdata[9:8];
      end
      // Write one clears; a new event in the same cycle wins
      tx_lpi_rcv_q <= p2_tx_lpi_ind | (tx_lpi_rcv_q & ~(sts_wr_hi & reg_wdata[`EEELPI_BIT_TX_LPI_RCV]));
      rx_lpi_rcv_q <= p2_rx_lpi_ind | (rx_lpi_rcv_q & ~(sts_wr_hi & reg_wdata[`EEELPI_BIT_RX_LPI_RCV]));
      // Clear on read; a new event in the same cycle wins
      pd_fault_q   <= p2_pd_fault | (pd_fault_q & ~sts_rd_lo);
      page_rcv_q   <= p2_page_rcv | (page_rcv_q & ~sts_rd_lo);
      if (reg_wr & hit_rec & reg_be[0]) begin
        rec_time_q <= reg_wdata[7:0];
      end
      if (reg_wr & hit_rec & reg_be[1]) begin
        np_res_q   <= reg_wdata[15:14];
        p2_np_en_q <= reg_wdata[8 + `EEELPI_BIT_P2_NP_EN];
        p1_np_en_q <= reg_wdata[8 + `EEELPI_BIT_P1_NP_EN];
      end
      if (reg_wr & hit_eqw & reg_be[0]) begin
        eq_wait_q[7:0] <= reg_wdata[7:0];
      end
      if (reg_wr & hit_eqw & reg_be[1]) begin
        eq_wait_q[15:8] <= reg_wdata[15:8];
      end
      if (reg_wr & hit_thr & reg_be[0]) begin
        buf_thr_q <= reg_wdata[7:0];
      end
    end
  end

  // Next-page exchange is left to the PHY; a cleared bit only takes hold at the next negotiation
  assign p2_np_en = p2_np_en_q;
  assign p1_np_en = p1_np_en_q;

  // ****************************************
  // Read path
  // ****************************************
  reg [15:0] sts_word;
  reg [15:0] rd_d;

  always @* begin
    sts_word                          = 16'h0000;
    sts_word[`EEELPI_BIT_RES15]       = res15_q;
    sts_word[`EEELPI_BIT_HW_EEE]      = eee_100bt_en[1];
    sts_word[`EEELPI_BIT_TX_LPI_RCV]  = tx_lpi_rcv_q;
    sts_word[`EEELPI_BIT_TX_LPI_IND]  = p2_tx_lpi_ind;
    sts_word[`EEELPI_BIT_RX_LPI_RCV]  = rx_lpi_rcv_q;
    sts_word[`EEELPI_BIT_RX_LPI_IND]  = p2_rx_lpi_ind;
    sts_word[9:8]                     = res98_q;
    sts_word[`EEELPI_BIT_NP_LOC_AB]   = 1'b1;
    sts_word[`EEELPI_BIT_NP_LOC]      = 1'b1;
    sts_word[`EEELPI_BIT_PD_FAULT]    = pd_fault_q;
    sts_word[`EEELPI_BIT_LP_NP_AB]    = p2_lp_np_able;
    sts_word[`EEELPI_BIT_NP_ABLE]     = 1'b1;
    sts_word[`EEELPI_BIT_PAGE_RCV]    = page_rcv_q;
    sts_word[`EEELPI_BIT_LP_AN_AB]    = p2_lp_an_able;
    rd_d = 16'h0000;
    if (hit_sts) begin
      rd_d = sts_word;
    end else if (hit_rec) begin
      rd_d = {np_res_q, 4'h0, p2_np_en_q, p1_np_en_q, rec_time_q};
    end else if (hit_eqw) begin
      rd_d = eq_wait_q;
    end else if (hit_thr) begin
      rd_d = {8'h00, buf_thr_q};
    end
  end

  always @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_d;
      end
    end
  end

  // ****************************************
  // Buffer load wake
  // ****************************************
  reg [NPORT-1:0] over_thr;
  integer         k;

  always @* begin
    over_thr = {NPORT{1'b0}};
    for (k = 0; k < NPORT; k = k + 1) begin
      over_thr[k] = (buf_usage[k*8 +: 8] > buf_thr_q);
    end
  end

  // ****************************************
  // Empty-queue LPI request
  // ****************************************
  wire [NPORT-1:0] eq_run;
  wire [NPORT-1:0] eq_done;

  // A wake also restarts every empty-queue timer, so LPI cannot return at once
  assign eq_run = transmit_queue_empty & eee_100bt_en & ~{NPORT{lpi_wake_all}};

  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_eq
      eeelpi_timer #(
        .PRE_CYC (EQ_UNIT_CYC),
        .PRE_W   (17),
        .CNT_W   (16)
      ) u_eq_timer (
        .clk     (core_clk),
        .rst_n   (rst_n_q),
        .run     (eq_run[g]),
        .restart (1'b0),
        .limit   (eq_wait_q),
        .done    (eq_done[g])
      );
    end
  endgenerate

  always @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lpi_wake_all <= 1'b0;
      lpi_req      <= {NPORT{1'b0}};
    end else begin
      lpi_wake_all <= |over_thr;
      lpi_req      <= eq_done & eee_100bt_en & ~{NPORT{|over_thr}};
    end
  end

  // ****************************************
  // Port 2 recovery hold-off
  // ****************************************
  wire rec_done;

  eeelpi_timer #(
    .PRE_CYC (`EEELPI_REC_UNIT_CYC),
    .PRE_W   (5),
    .CNT_W   (8)
  ) u_rec_timer (
    .clk     (core_clk),
    .rst_n   (rst_n_q),
    .run     (p2_tx_hold),
    .restart (p2_lpi_exit),
    .limit   (rec_time_q),
    .done    (rec_done)
  );

  always @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      p2_tx_hold <= 1'b0;
    end else if (p2_lpi_exit) begin
      p2_tx_hold <= 1'b1;
    end else if (rec_done) begin
      p2_tx_hold <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: verification/eeelpi_monitor.sv */
// Port checker of the EEE low-power-idle control block.
// Assumes one clock domain; bound to eeelpi_top below.
`timescale 1ns/1ps
`default_nettype none
module eeelpi_monitor #(parameter NPORT = 3) (
  // Clock and reset
  input wire logic               core_clk,
  input wire logic               rst_b,
  // Register port
  input wire logic [7:0]         reg_addr,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [1:0]         reg_be,
  input wire logic [15:0]        reg_wdata,
  input wire logic [15:0]        reg_rdata,
  input wire logic               reg_rvalid,
  // Link status
  input wire logic               p2_page_rcv,
  input wire logic               p2_lp_an_able,
  input wire logic [NPORT-1:0]   eee_100bt_en,
  // LPI control
  input wire logic [NPORT-1:0]   transmit_queue_empty,
  input wire logic [NPORT*8-1:0] buf_usage,
  input wire logic               p2_lpi_exit,
  input wire logic               p2_tx_hold,
  input wire logic               p1_np_en,
  input wire logic               p2_np_en,
  input wire logic [NPORT-1:0]   lpi_req,
  input wire logic               lpi_wake_all
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire st_rd = reg_rd && reg_addr[7:1] == 7'h78;
  wire np_wr = reg_wr && reg_addr[7:1] == 7'h79 && reg_be[1];
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  a_np_able_one: assert property ($past(st_rd) |-> reg_rdata[2])
    else $error("next page able bit low");
  a_page_latch: assert property (p2_page_rcv ##1 st_rd |=> reg_rdata[1])
    else $error("page received lost");
  a_partner_able: assert property ($past(st_rd) |-> reg_rdata[0] == $past(p2_lp_an_able))
    else $error("partner able bit wrong");
  a_hw_eee_bit: assert property ($past(st_rd) |-> reg_rdata[14] == $past(eee_100bt_en[1]))
    else $error("eee status bit wrong");
  a_np_write: assert property (np_wr |=> {p2_np_en, p1_np_en} == $past(reg_wdata[9:8]))
    else $error("next page enable not written");
  a_req_cause: assert property (lpi_req != 0 |-> (lpi_req & ~$past(eee_100bt_en & transmit_queue_empty)) == 0)
    else $error("lpi request without cause");
  a_wake_ends: assert property (lpi_wake_all |-> lpi_req == 0)
    else $error("lpi request during wake");
  a_idle_no_wake: assert property (buf_usage == 0 |=> !lpi_wake_all)
    else $error("wake with empty buffers");
  a_hold_exit: assert property (p2_lpi_exit |=> p2_tx_hold [*2])
    else $error("no hold after recovery");
endmodule
bind eeelpi_top eeelpi_monitor #(.NPORT(NPORT)) i_eeelpi_monitor (.core_clk, .rst_b, .reg_addr, .reg_wr,
  .reg_rd, .reg_be, .reg_wdata, .reg_rdata, .reg_rvalid, .p2_page_rcv, .p2_lp_an_able, .eee_100bt_en,
  .transmit_queue_empty, .buf_usage, .p2_lpi_exit, .p2_tx_hold, .p1_np_en, .p2_np_en, .lpi_req, .lpi_wake_all);
`default_nettype wire

/* File: verification/eeelpi_partner.sv */
// Link partner model: sends pages and shows its abilities.
// Assumes bench commands on core_clk; delay picks a prompt or slow page.
`timescale 1ns/1ps
`default_nettype none
module eeelpi_partner (
  // Clock
  input  wire logic       core_clk,
  // Bench commands
  input  wire logic       send_page,
  input  wire logic [3:0] delay,
  input  wire logic       an_able,
  // Toward the device
  output logic            page_rcv,
  output logic            lp_an_able,
  output logic            lp_np_able
);
  logic [4:0] cnt_q = 5'h00;
  assign lp_an_able = an_able;
  assign lp_np_able = an_able;
  // A page is a one-cycle event; it is never repeated
  always @(posedge core_clk) begin
    page_rcv <= cnt_q == 5'h01;
    if (send_page)
      cnt_q <= {1'b0, delay} + 5'h01;
    else if (cnt_q != 5'h00)
      cnt_q <= cnt_q - 5'h01;
  end
endmodule
`default_nettype wire

/* File: verification/test_eee_low_power_idle_control.sv */
// Self-checking bench of the EEE low-power-idle control block.
// Assumes eeelpi_top, the partner model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_eee_low_power_idle_control;
  typedef struct packed {logic w; logic [7:0] a; logic [1:0] be; logic [15:0] d, e;} eeelpi_row_t;
  logic        core_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [1:0]  reg_be = 2'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rdat;
  logic        reg_rvalid, p2_page_rcv, p2_lp_an_able, p2_lp_np_able, p2_tx_hold, p1_np_en, p2_np_en;
  logic        lpi_wake_all, send_page = 1'b0, an_able = 1'b0, p2_lpi_exit = 1'b0;
  logic [3:0]  pdelay = 4'h5;
  logic [2:0]  eee_100bt_en = 3'h0, transmit_queue_empty = 3'h0, lpi_req;
  logic [23:0] buf_usage = 24'h000000;
  int          n_checks = 0, n_mismatch = 0, n;
  // ******
  // Rows: optional write, then read back
  // ******
  eeelpi_row_t rows [9] = '{
    '{1'h0, 8'hF0, 2'h0, 16'h0000, 16'h8064},
    '{1'h0, 8'hF2, 2'h0, 16'h0000, 16'h0227},
    '{1'h0, 8'hF4, 2'h0, 16'h0000, 16'h03E8},
    '{1'h0, 8'hF6, 2'h0, 16'h0000, 16'h0004},
    '{1'h1, 8'hF8, 2'h3, 16'hFFFF, 16'h0000},
    '{1'h1, 8'hF2, 2'h2, 16'hFF00, 16'hC327},
    '{1'h1, 8'hF6, 2'h3, 16'hFFFF, 16'h00FF},
    '{1'h1, 8'hF4, 2'h3, 16'h0002, 16'h0002},
    '{1'h1, 8'hF2, 2'h3, 16'h0003, 16'h0003}};
  eeelpi_top #(.NPORT(3), .EQ_UNIT_CYC(4)) i_eeelpi_top (.core_clk, .rst_b, .reg_addr, .reg_wr,
    .reg_rd, .reg_be, .reg_wdata, .reg_rdata, .reg_rvalid, .p2_page_rcv, .p2_lp_an_able, .p2_lp_np_able,
    .p2_pd_fault(1'b0), .p2_tx_lpi_ind(1'b0), .p2_rx_lpi_ind(1'b0), .eee_100bt_en, .transmit_queue_empty,
    .buf_usage, .p2_lpi_exit, .p2_tx_hold, .p1_np_en, .p2_np_en, .lpi_req, .lpi_wake_all);
  eeelpi_partner i_eeelpi_partner (.core_clk, .send_page, .delay(pdelay), .an_able,
    .page_rcv(p2_page_rcv), .lp_an_able(p2_lp_an_able), .lp_np_able(p2_lp_np_able));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic tick(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    reg_addr = a;
    reg_be = be;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    // One idle edge between strobes, so a following call never re-raises it in the same step
    tick(1);
  endtask
  // The answer stands one cycle, so it is taken right after the read edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk("reg_rvalid", 16'h0001, reg_rvalid);
    d = reg_rdata;
    tick(1);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    tick(3);
    rst_b = 1'b1;
    tick(3);
    chk("np_en reset", 16'h0002, {p2_np_en, p1_np_en});
    foreach (rows[i]) begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].be, rows[i].d);
      rd(rows[i].a, rdat);
      chk("register", rows[i].e, rdat);
    end
    chk("np_en off", 16'h0000, {p2_np_en, p1_np_en});
    // Slow partner page lands the cycle before the read
    an_able = 1'b1;
    send_page = 1'b1;
    tick(1);
    send_page = 1'b0;
    tick(7);
    rd(8'hF0, rdat);
    chk("status page", 16'h806F, rdat);
    rd(8'hF0, rdat);
    chk("status clear", 16'h806D, rdat);
    wr(8'hF6, 2'h3, 16'h0010);
    wr(8'hF4, 2'h3, 16'h0002);
    eee_100bt_en = 3'h3;
    transmit_queue_empty = 3'h7;
    tick(7);
    chk("lpi_req early", 16'h0000, lpi_req);
    tick(4);
    chk("lpi_req", 16'h0003, lpi_req);
    rd(8'hF0, rdat);
    chk("status eee", 16'hC06D, rdat);
    buf_usage = 24'h001000;
    tick(3);
    chk("wake at limit", 16'h0003, {lpi_wake_all, lpi_req});
    buf_usage = 24'h110000;
    tick(2);
    chk("wake all", 16'h0008, {lpi_wake_all, lpi_req});
    buf_usage = 24'h000000;
    tick(2);
    chk("wake end", 16'h0000, {lpi_wake_all, lpi_req});
    tick(11);
    chk("lpi_req again", 16'h0003, lpi_req);
    p2_lpi_exit = 1'b1;
    tick(1);
    p2_lpi_exit = 1'b0;
    chk("hold start", 16'h0001, p2_tx_hold);
    tick(72);
    for (n = 0; n < 20 && p2_tx_hold === 1'b1; n++)
      tick(1);
    chk("hold end", 16'h0001, n inside {[3:12]});
    if (n == 20)
      wrap_up();
    rst_b = 1'b0;
    tick(3);
    chk("reset outputs", 16'h0002, {lpi_wake_all, lpi_req, p2_np_en, p1_np_en});
    rst_b = 1'b1;
    tick(3);
    rd(8'hF2, rdat);
    chk("recovery reset", 16'h0227, rdat);
    wrap_up();
  end
endmodule
`default_nettype wire
